//--- blc_backlight_control_registers.v
// backlight control register bank with the logic its fields steer
//
// Contract
// - Over-voltage limit codes 0..3 give 17, 21, 25, 29 V and codes 4..7 give 29 V.
// - Over-voltage response 0 only reports the event, 1 shuts the backlight down.
// - The PWM input is active high when polarity is 0 and active low when it is 1.
// - With the ramp bit set the current ramps after each duty change, else it follows at once.
// - The PWM input is used only while the PWM enable bit is 1.
// - Boost frequency bit selects 500 kHz at 0 and 1 MHz at 1, resetting to 1.
// - The transition-time field sets the time to move to a new code, 0 immediate to 8 s; each one-code step waits that time over the codes left.
// - Sample bit picks 1 MHz or 4 MHz PWM sampling, overridden to 24 MHz by the option input; the fast divider of 2 samples at 20 MHz.
// - Hysteresis codes mean 1,2,4,6 bits at 1/4 MHz sampling and 0,1,2,3 bits at 24 MHz.
// - The 11-bit code is the high register as bits 10:3 and low register bits 2:0.
// - Both auto-frequency thresholds compare with the upper eight code bits.
`timescale 1ns/1ps
`default_nettype none
`include "blc_consts.vh"
module blc_backlight_control_registers #(
  parameter TT_SCALE = 1
) (
  input wire clock,
  input wire reset,
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  input wire pwmIn,
  input wire fastSampleSelect,
  input wire overvoltageDetect,
  input wire sinkOneOn,
  input wire sinkTwoOn,
  input wire backlightOn,
  output reg [10:0] brightnessCode,
  output reg [10:0] ledLevel,
  output reg [7:0] overvoltageLimitVolts,
  output reg overvoltageReport,
  output reg backlightShutdown,
  output reg [9:0] boostSwitchKhz,
  output reg boostClockTick,
  output reg autofreqBelowLow,
  output reg autofreqAboveHigh,
  output reg settingsChangedWhileOn
);
  localparam SAMPLE_DIV_LO = `BLC_CLK_MHZ / `BLC_SAMPLE_LO_MHZ;
  localparam SAMPLE_DIV_HI = `BLC_CLK_MHZ / `BLC_SAMPLE_HI_MHZ;
  localparam SAMPLE_DIV_FAST = (`BLC_CLK_MHZ + `BLC_SAMPLE_FAST_MHZ - 1) / `BLC_SAMPLE_FAST_MHZ;
  localparam BOOST_HALF_LO = (`BLC_CLK_MHZ * 1000) / (2 * `BLC_BOOST_LO_KHZ);
  localparam BOOST_HALF_HI = (`BLC_CLK_MHZ * 1000) / (2 * `BLC_BOOST_HI_KHZ);
  localparam PWM_PERIOD = 2048;
  localparam ST_IDLE = 2'b01;
  localparam ST_RAMP = 2'b10;

  reg [7:0] cfgOne, cfgTwo, brLow, brHigh, afLow, afHigh;
  wire [2:0] memIndex;
  wire [7:0] memRead;
  wire addrHit;

  assign addrHit = (regAddr >= `BLC_ADDR_CFG1) && (regAddr <= `BLC_ADDR_AFHI);
  assign memIndex = regAddr[2:0] - 3'd2;

  blc_reg_mem #(.DEPTH(6)) regMem (
    .clock(clock),
    .reset(reset),
    .writeEnable(regWrite && addrHit),
    .writeIndex(memIndex),
    .writeData(regWriteData),
    .readIndex(memIndex),
    .readData(memRead)
  );

  // shadow copies feed the logic without a memory read port per field
  always @(posedge clock) begin
    if (reset) begin
      cfgOne <= `BLC_RST_CFG1;
      cfgTwo <= `BLC_RST_CFG2;
      brLow <= `BLC_RST_BRLO;
      brHigh <= `BLC_RST_BRHI;
      afLow <= `BLC_RST_AF;
      afHigh <= `BLC_RST_AF;
      regReadData <= 8'h00;
    end else begin
      if (regWrite) begin
        case (regAddr)
          `BLC_ADDR_CFG1: cfgOne <= regWriteData;
          `BLC_ADDR_CFG2: cfgTwo <= regWriteData;
          `BLC_ADDR_BRLO: brLow <= {5'h00, regWriteData[2:0]};
          `BLC_ADDR_BRHI: brHigh <= regWriteData;
          `BLC_ADDR_AFLO: afLow <= regWriteData;
          `BLC_ADDR_AFHI: afHigh <= regWriteData;
          default: ;
        endcase
      end
      regReadData <= addrHit ? memRead : 8'h00;
    end
  end

  wire [2:0] ovLimit = cfgOne[`BLC_CFG1_OVLIM_LO +: 3];
  wire ovResp = cfgOne[`BLC_CFG1_OVRESP];
  wire pwmPolarity = cfgOne[`BLC_CFG1_POL];
  wire rampOn = cfgOne[`BLC_CFG1_RAMP];
  wire pwmEnable = cfgOne[`BLC_CFG1_PWMEN];
  wire boostFast = cfgTwo[`BLC_CFG2_BOOST];
  wire [3:0] transTime = cfgTwo[`BLC_CFG2_TT_LO +: 4];
  wire sampleHi = cfgTwo[`BLC_CFG2_SAMPLE];
  wire [1:0] hyst = cfgTwo[`BLC_CFG2_HYST_LO +: 2];
  wire [10:0] regCode = {brHigh, brLow[2:0]};
  wire enabled = backlightOn || sinkOneOn || sinkTwoOn;

  function [7:0] ovlimDecode;
    input [2:0] code;
    begin
      case (code)
        3'd0: ovlimDecode = `BLC_OVLIM_V0;
        3'd1: ovlimDecode = `BLC_OVLIM_V1;
        3'd2: ovlimDecode = `BLC_OVLIM_V2;
        default: ovlimDecode = `BLC_OVLIM_V3;
      endcase
    end
  endfunction

  // transition time in 250 us units; middle codes follow a monotone guess
  function [15:0] ttQuarterMs;
    input [3:0] code;
    begin
      case (code)
        4'h0: ttQuarterMs = 16'd0;
        4'h1: ttQuarterMs = 16'd2;
        4'h2: ttQuarterMs = 16'd3;
        4'h3: ttQuarterMs = 16'd4;
        4'h4: ttQuarterMs = 16'd8;
        4'h5: ttQuarterMs = 16'd20;
        4'h6: ttQuarterMs = 16'd200;
        4'h7: ttQuarterMs = 16'd300;
        4'h8: ttQuarterMs = 16'd400;
        4'h9: ttQuarterMs = 16'd1000;
        4'ha: ttQuarterMs = 16'd2000;
        4'hb: ttQuarterMs = 16'd3200;
        4'hc: ttQuarterMs = 16'd4000;
        4'hd: ttQuarterMs = 16'd8000;
        4'he: ttQuarterMs = 16'd16000;
        default: ttQuarterMs = 16'd32000;
      endcase
    end
  endfunction

  function [10:0] hystBits;
    input [1:0] code;
    input fast;
    begin
      if (fast) begin
        hystBits = {9'd0, code};
      end else begin
        case (code)
          2'd0: hystBits = 11'd1;
          2'd1: hystBits = 11'd2;
          2'd2: hystBits = 11'd4;
          default: hystBits = 11'd6;
        endcase
      end
    end
  endfunction

  // pwm sampling strobe, duty measured over a fixed window of samples
  reg [5:0] sampleCount;
  reg [10:0] windowCount, highCount, dutyCode;
  wire [5:0] sampleDiv = fastSampleSelect ? SAMPLE_DIV_FAST[5:0] :
    (sampleHi ? SAMPLE_DIV_HI[5:0] : SAMPLE_DIV_LO[5:0]);
  wire sampleTick = (sampleCount >= sampleDiv - 6'd1);
  wire pwmActive = pwmIn ^ pwmPolarity;
  // the window's last sample counts too; a fully active input saturates
  wire [11:0] windowHigh = {1'b0, highCount} + {11'd0, pwmActive};
  wire [10:0] windowDuty = windowHigh[11] ? 11'h7ff : windowHigh[10:0];

  always @(posedge clock) begin
    if (reset) begin
      sampleCount <= 6'd0;
      windowCount <= 11'd0;
      highCount <= 11'd0;
      dutyCode <= 11'h7ff;
    end else begin
      sampleCount <= sampleTick ? 6'd0 : sampleCount + 6'd1;
      if (sampleTick) begin
        windowCount <= windowCount + 11'd1;
        if (windowCount == PWM_PERIOD - 1) begin
          highCount <= 11'd0;
          // small duty moves are held back so jitter does not flicker
          // widened so a sum near full scale cannot wrap
          if ({1'b0, windowDuty} > {1'b0, dutyCode} + {1'b0, hystBits(hyst, fastSampleSelect)} ||
              {1'b0, dutyCode} > {1'b0, windowDuty} + {1'b0, hystBits(hyst, fastSampleSelect)}) begin
            dutyCode <= windowDuty;
          end
        end else if (pwmActive) begin
          highCount <= highCount + 11'd1;
        end
      end
    end
  end

  // target code: register code scaled by duty when pwm is enabled
  wire [21:0] scaled = regCode * dutyCode;
  wire [10:0] targetPwm = pwmEnable ? scaled[21:11] : regCode;
  reg [10:0] lastDuty;

  // ramp engine: one-code steps, each waiting the transition time over the codes still to go
  localparam [15:0] QMS_CYCLES = 16'd10000;
  reg [1:0] state;
  reg [31:0] stepTimer, stepPeriod;
  reg [10:0] rampTarget;
  wire [10:0] stepSize = (rampTarget > ledLevel) ? rampTarget - ledLevel : ledLevel - rampTarget;
  wire dutyChanged = pwmEnable && (dutyCode != lastDuty);
  wire skipRamp = dutyChanged && !rampOn;

  always @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
      ledLevel <= 11'h7ff;
      rampTarget <= 11'h7ff;
      stepTimer <= 32'd0;
      stepPeriod <= 32'd0;
      lastDuty <= 11'h7ff;
    end else begin
      lastDuty <= dutyCode;
      case (state)
        ST_IDLE: begin
          if (targetPwm != ledLevel) begin
            if (skipRamp || ttQuarterMs(transTime) == 16'd0) begin
              ledLevel <= targetPwm;
            end else begin
              rampTarget <= targetPwm;
              stepTimer <= 32'd0;
              state <= ST_RAMP;
            end
          end
        end
        ST_RAMP: begin
          // per-step period is the chosen time divided by the codes still to go, redone each cycle
          stepPeriod <= (ttQuarterMs(transTime) * QMS_CYCLES * TT_SCALE) /
            ((stepSize == 11'd0) ? 32'd1 : {21'd0, stepSize});
          if (ledLevel == rampTarget || skipRamp) begin
            ledLevel <= skipRamp ? targetPwm : ledLevel;
            state <= ST_IDLE;
          end else if (stepTimer >= stepPeriod) begin
            stepTimer <= 32'd0;
            ledLevel <= (rampTarget > ledLevel) ? ledLevel + 11'd1 : ledLevel - 11'd1;
          end else begin
            stepTimer <= stepTimer + 32'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // boost switching clock
  reg [5:0] boostCount;
  wire [5:0] boostHalf = boostFast ? BOOST_HALF_HI[5:0] : BOOST_HALF_LO[5:0];
  always @(posedge clock) begin
    if (reset) begin
      boostCount <= 6'd0;
      boostClockTick <= 1'b0;
      boostSwitchKhz <= 10'd0;
    end else begin
      boostSwitchKhz <= boostFast ? `BLC_BOOST_HI_KHZ : `BLC_BOOST_LO_KHZ;
      if (boostCount >= boostHalf - 6'd1 || backlightShutdown) begin
        boostCount <= 6'd0;
        boostClockTick <= ~boostClockTick & ~backlightShutdown;
      end else begin
        boostCount <= boostCount + 6'd1;
      end
    end
  end

  // protection, thresholds, outputs
  always @(posedge clock) begin
    if (reset) begin
      overvoltageLimitVolts <= `BLC_OVLIM_V1;
      overvoltageReport <= 1'b0;
      backlightShutdown <= 1'b0;
      brightnessCode <= 11'h7ff;
      autofreqBelowLow <= 1'b0;
      autofreqAboveHigh <= 1'b0;
      settingsChangedWhileOn <= 1'b0;
    end else begin
      overvoltageLimitVolts <= ovlimDecode(ovLimit);
      overvoltageReport <= overvoltageDetect;
      // shutdown latches until the backlight is switched off
      if (overvoltageDetect && ovResp) begin
        backlightShutdown <= 1'b1;
      end else if (!backlightOn) begin
        backlightShutdown <= 1'b0;
      end
      brightnessCode <= regCode;
      autofreqBelowLow <= brHigh < afLow;
      autofreqAboveHigh <= brHigh > afHigh;
      // sticky warning, cleared by reset only
      if (regWrite && enabled &&
          (regAddr == `BLC_ADDR_CFG1 || regAddr == `BLC_ADDR_CFG2 ||
           regAddr == `BLC_ADDR_AFLO || regAddr == `BLC_ADDR_AFHI)) begin
        settingsChangedWhileOn <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- blc_consts.vh
// register offsets, field positions, reset values and timing counts for the backlight controls
`ifndef BLC_CONSTS_VH
`define BLC_CONSTS_VH
`define BLC_ADDR_CFG1 8'h02
`define BLC_ADDR_CFG2 8'h03
`define BLC_ADDR_BRLO 8'h04
`define BLC_ADDR_BRHI 8'h05
`define BLC_ADDR_AFLO 8'h06
`define BLC_ADDR_AFHI 8'h07
`define BLC_RST_CFG1 8'h28
`define BLC_RST_CFG2 8'h8d
`define BLC_RST_BRLO 8'h07
`define BLC_RST_BRHI 8'hff
`define BLC_RST_AF 8'h00
`define BLC_CFG1_PWMEN 0
`define BLC_CFG1_RAMP 1
`define BLC_CFG1_POL 2
`define BLC_CFG1_MAP 3
`define BLC_CFG1_OVRESP 4
`define BLC_CFG1_OVLIM_LO 5
`define BLC_CFG2_HYST_LO 0
`define BLC_CFG2_SAMPLE 2
`define BLC_CFG2_TT_LO 3
`define BLC_CFG2_BOOST 7
`define BLC_CLK_MHZ 40
`define BLC_SAMPLE_LO_MHZ 1
`define BLC_SAMPLE_HI_MHZ 4
`define BLC_SAMPLE_FAST_MHZ 24
`define BLC_BOOST_LO_KHZ 10'd500
`define BLC_BOOST_HI_KHZ 10'd1000
`define BLC_OVLIM_V0 8'd17
`define BLC_OVLIM_V1 8'd21
`define BLC_OVLIM_V2 8'd25
`define BLC_OVLIM_V3 8'd29
`endif

//--- blc_reg_mem.v
// small register memory for the backlight control words, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "blc_consts.vh"
module blc_reg_mem #(
  parameter DEPTH = 6
) (
  input wire clock,
  input wire reset,
  input wire writeEnable,
  input wire [2:0] writeIndex,
  input wire [7:0] writeData,
  input wire [2:0] readIndex,
  output reg [7:0] readData
);
  reg [7:0] mem [0:DEPTH-1];
  integer i;

  function [7:0] resetValue;
    input integer idx;
    begin
      case (idx)
        0: resetValue = `BLC_RST_CFG1;
        1: resetValue = `BLC_RST_CFG2;
        2: resetValue = `BLC_RST_BRLO;
        3: resetValue = `BLC_RST_BRHI;
        default: resetValue = `BLC_RST_AF;
      endcase
    end
  endfunction

  always @(posedge clock) begin
    if (reset) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= resetValue(i);
      end
      readData <= 8'h00;
    end else begin
      if (writeEnable && writeIndex < DEPTH) begin
        // brightness low register keeps its unused upper bits at zero
        mem[writeIndex] <= (writeIndex == 3'd2) ? {5'h00, writeData[2:0]} : writeData;
      end
      readData <= (readIndex < DEPTH) ? mem[readIndex] : 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- blc_properties.sv
// port assertions for the backlight control register bank
`timescale 1ns/1ps
`default_nettype none
module blc_properties #(parameter TT_SCALE = 1) (
  input wire logic clock,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic pwmIn,
  input wire logic fastSampleSelect,
  input wire logic overvoltageDetect,
  input wire logic sinkOneOn,
  input wire logic sinkTwoOn,
  input wire logic backlightOn,
  input wire logic [10:0] brightnessCode,
  input wire logic [10:0] ledLevel,
  input wire logic [7:0] overvoltageLimitVolts,
  input wire logic overvoltageReport,
  input wire logic backlightShutdown,
  input wire logic [9:0] boostSwitchKhz,
  input wire logic boostClockTick,
  input wire logic autofreqBelowLow,
  input wire logic autofreqAboveHigh,
  input wire logic settingsChangedWhileOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] cfg1Sh, cfg2Sh, afLoSh, afHiSh;
  logic [3:0] idleCnt;
  always @(posedge clock) begin
    if (reset || regWrite) begin
      idleCnt <= 4'h0;
    end else if (idleCnt != 4'hf) begin
      idleCnt <= idleCnt + 4'h1;
    end
    if (reset) begin
      cfg1Sh <= 8'h28;
      cfg2Sh <= 8'h8d;
      afLoSh <= 8'h00;
      afHiSh <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == 8'h02) cfg1Sh <= regWriteData;
      if (regAddr == 8'h03) cfg2Sh <= regWriteData;
      if (regAddr == 8'h06) afLoSh <= regWriteData;
      if (regAddr == 8'h07) afHiSh <= regWriteData;
    end
  end
  function automatic logic [7:0] ovVolts(input logic [2:0] c);
    return (c == 3'h0) ? 8'd17 : (c == 3'h1) ? 8'd21 : (c == 3'h2) ? 8'd25 : 8'd29;
  endfunction
  sequence sWrite(a);
    regWrite && regAddr == a;
  endsequence
  AST_OV_VOLTS: assert property (sWrite(8'h02) |-> ##2
    overvoltageLimitVolts == ovVolts($past(regWriteData[7:5], 2))) else $error("ov limit");
  AST_OV_REPORT_ONLY: assert property (overvoltageDetect && !cfg1Sh[4] && idleCnt > 4'h1
    && !backlightShutdown |=> !backlightShutdown) else $error("report only shut down");
  AST_OV_SHUTDOWN: assert property (overvoltageDetect && cfg1Sh[4] && backlightOn
    && idleCnt > 4'h1 |-> ##[1:2] backlightShutdown) else $error("no shutdown");
  AST_BOOST: assert property (sWrite(8'h03) |-> ##2
    boostSwitchKhz == ($past(regWriteData[7], 2) ? 10'd1000 : 10'd500)) else $error("boost");
  AST_BOOST_RESET: assert property ($fell(reset) |=> boostSwitchKhz == 10'd1000)
    else $error("boost reset");
  AST_BOOST_HALT: assert property (backlightShutdown |=> !boostClockTick)
    else $error("boost runs in shutdown");
  AST_CHANGE_FLAG: assert property ($rose(settingsChangedWhileOn) |->
    $past(regWrite && (sinkOneOn || sinkTwoOn || backlightOn))) else $error("change flag");
  AST_CODE_HI: assert property (sWrite(8'h05) |-> ##2
    brightnessCode[10:3] == $past(regWriteData, 2)) else $error("code high");
  AST_CODE_LO: assert property (sWrite(8'h04) |-> ##2
    brightnessCode[2:0] == $past(regWriteData[2:0], 2)) else $error("code low");
  AST_AF_LOW: assert property (idleCnt == 4'h3 |->
    autofreqBelowLow == (brightnessCode[10:3] < afLoSh)) else $error("af low");
  AST_AF_HIGH: assert property (idleCnt == 4'h3 |->
    autofreqAboveHigh == (brightnessCode[10:3] > afHiSh)) else $error("af high");
  AST_PWM_IGNORED: assert property (idleCnt == 4'h4 && !cfg1Sh[0] && cfg2Sh[6:3] == 4'h0
    && !backlightShutdown |-> ledLevel == brightnessCode) else $error("level");
endmodule
bind blc_backlight_control_registers blc_properties #(.TT_SCALE(TT_SCALE)) blc_properties_inst (
  .clock, .reset, .regWrite, .regAddr, .regWriteData, .regReadData, .pwmIn, .fastSampleSelect,
  .overvoltageDetect, .sinkOneOn, .sinkTwoOn, .backlightOn, .brightnessCode, .ledLevel,
  .overvoltageLimitVolts, .overvoltageReport, .backlightShutdown, .boostSwitchKhz,
  .boostClockTick, .autofreqBelowLow, .autofreqAboveHigh, .settingsChangedWhileOn);
`default_nettype wire

//--- blc_pwm_source.sv
// external pwm brightness source, settable period and settable high time
`timescale 1ns/1ps
`default_nettype none
module blc_pwm_source (
  input wire logic clock,
  input wire logic [7:0] periodCycles,
  input wire logic [7:0] highCycles,
  output logic pwmOut
);
  logic [7:0] phase = 8'h00;
  initial pwmOut = 1'b0;
  always @(posedge clock) begin
    phase <= (phase + 8'h01 >= periodCycles) ? 8'h00 : phase + 8'h01;
    pwmOut <= phase < highCycles;
  end
endmodule
`default_nettype wire

//--- test_backlight_control_registers.sv
// self-checking bench for the backlight control register bank
`timescale 1ns/1ps
`default_nettype none
module test_backlight_control_registers;
  logic clock, reset, regWrite, pwmIn, fastSampleSelect, overvoltageDetect, backlightOn;
  logic [7:0] regAddr, regWriteData, regReadData, overvoltageLimitVolts, v;
  logic [10:0] brightnessCode, ledLevel;
  logic [9:0] boostSwitchKhz;
  logic overvoltageReport, backlightShutdown, autofreqBelowLow, autofreqAboveHigh;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [23:0] rows [0:7] = '{24'h030404, 24'h02e0e0, 24'h04fa02, 24'h058080,
    24'h069090, 24'h077070, 24'h095500, 24'h038484};
  logic [7:0] rstVal [0:5] = '{8'h28, 8'h8d, 8'h07, 8'hff, 8'h00, 8'h00};
  logic [7:0] volts [0:7] = '{8'd17, 8'd21, 8'd25, 8'd29, 8'd29, 8'd29, 8'd29, 8'd29};
  blc_backlight_control_registers #(.TT_SCALE(1)) blc_backlight_control_registers_inst (
    .clock, .reset, .regWrite, .regAddr, .regWriteData, .regReadData, .pwmIn,
    .fastSampleSelect, .overvoltageDetect, .sinkOneOn(1'b0), .sinkTwoOn(1'b0), .backlightOn,
    .brightnessCode, .ledLevel, .overvoltageLimitVolts, .overvoltageReport,
    .backlightShutdown, .boostSwitchKhz, .boostClockTick(), .autofreqBelowLow,
    .autofreqAboveHigh, .settingsChangedWhileOn());
  blc_pwm_source blc_pwm_source_inst (.clock, .periodCycles(8'd8), .highCycles(8'd2),
    .pwmOut(pwmIn));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic wrap_up;
    $display("compared %0d, wrong %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    settle();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    settle();
    v = regReadData;
  endtask
  // bounded wait: the duty window spans 2048 samples
  task automatic waitLevel(input logic [10:0] exp);
    int i;
    for (i = 0; i < 8000 && ledLevel !== exp; i++) settle();
    if (i == 8000) begin
      n_mismatch++;
      wrap_up();
    end
    check(ledLevel, exp);
  endtask
  initial begin
    reset = 1'b1;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    fastSampleSelect = 1'b0;
    overvoltageDetect = 1'b0;
    backlightOn = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    settle();
    check(brightnessCode, 11'h7ff);
    check(boostSwitchKhz, 10'd1000);
    for (int i = 0; i < 6; i++) begin
      rd(8'h02 + 8'(i));
      check(v, rstVal[i]);
    end
    $display("reset values done");
    // all settings written while every enable is low
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check(v, rows[i][7:0]);
    end
    check(brightnessCode, 11'h402);
    check(autofreqBelowLow, 1'b1);
    check(autofreqAboveHigh, 1'b1);
    $display("register rows done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h02, 8'(i << 5));
      check(overvoltageLimitVolts, volts[i]);
    end
    wr(8'h03, 8'h04);
    check(boostSwitchKhz, 10'd500);
    wr(8'h03, 8'h84);
    wr(8'h07, 8'h80);
    check(autofreqAboveHigh, 1'b0);
    $display("decode tests done");
    wr(8'h02, 8'h00);
    @(posedge clock);
    backlightOn <= 1'b1;
    overvoltageDetect <= 1'b1;
    settle();
    check(overvoltageReport, 1'b1);
    check(backlightShutdown, 1'b0);
    @(posedge clock);
    backlightOn <= 1'b0;
    overvoltageDetect <= 1'b0;
    wr(8'h02, 8'h10);
    @(posedge clock);
    backlightOn <= 1'b1;
    overvoltageDetect <= 1'b1;
    settle();
    check(backlightShutdown, 1'b1);
    @(posedge clock);
    backlightOn <= 1'b0;
    overvoltageDetect <= 1'b0;
    settle();
    check(backlightShutdown, 1'b0);
    $display("overvoltage tests done");
    // fast sampling keeps each window short; hysteresis code 0 is zero bits here
    @(posedge clock);
    fastSampleSelect <= 1'b1;
    wr(8'h02, 8'h01);
    waitLevel(11'd256);
    wr(8'h02, 8'h05);
    waitLevel(11'd769);
    wr(8'h02, 8'h00);
    waitLevel(11'h402);
    $display("pwm tests done");
    wrap_up();
  end
endmodule
`default_nettype wire
